// ===== hdl/serial_flash_read_path.sv
// read path of a serial flash target: spi pin front end, prefetch and fifo
// assumes the array port answers in order, one response per accepted request
`timescale 1ns/1ps

module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic flush,
	// fill side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// drain side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [WIDTH-1:0] mem_next [DEPTH];
	logic [PW-1:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
	logic [PW:0] count_reg, count_next;
	logic push, pop;

	// honest full and empty from the occupancy count
	assign inReady = (count_reg != (PW+1)'(DEPTH));
	assign outValid = (count_reg != '0);
	assign outData = mem_reg[rdPtr_reg];
	assign push = inValid & inReady;
	assign pop = outValid & outReady;

	// pointer and storage update; flush wins over a push in the same cycle
	always_comb begin
		mem_next = mem_reg;
		wrPtr_next = wrPtr_reg;
		rdPtr_next = rdPtr_reg;
		count_next = count_reg;
		if (flush) begin
			wrPtr_next = '0;
			rdPtr_next = '0;
			count_next = '0;
		end else begin
			if (push) begin
				mem_next[wrPtr_reg] = inData;
				wrPtr_next = (wrPtr_reg == PW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
			end
			if (pop) begin
				rdPtr_next = (rdPtr_reg == PW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
			end
			count_next = count_reg + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
		end else begin
			wrPtr_reg <= wrPtr_next;
			rdPtr_reg <= rdPtr_next;
			count_reg <= count_next;
			mem_reg <= mem_next;
		end
	end
endmodule : byte_fifo

module serial_flash_read_path
	import flash_read_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// spi pins, inputs asynchronous to ref_clk
	input wire logic csN,
	input wire logic sclk,
	input wire logic [3:0] ioIn,
	output logic [3:0] ioOut,
	output logic [3:0] ioOe,
	// status bit from the rest of the device
	input wire logic quadEnable,
	// array read request
	output logic memReqValid,
	input wire logic memReqReady,
	output logic [ARRAY_ADDR_W-1:0] memReqAddr,
	// array read response
	input wire logic memRspValid,
	output logic memRspReady,
	input wire logic [DATA_W-1:0] memRspData
);
	logic [5:0] syncA_reg, syncB_reg;
	logic sclkPrev_reg, csPrev_reg;
	logic csSync, sclkSync, sclkRise, sclkFall, csFall;
	logic [3:0] ioSync;

	phase_t state_reg, state_next;
	logic [2:0] addrLanes_reg, addrLanes_next, dataLanes_reg, dataLanes_next;
	logic hasMode_reg, hasMode_next;
	logic [4:0] dummyClks_reg, dummyClks_next, clkCnt_reg, clkCnt_next;
	logic [23:0] shift_reg, shift_next;
	logic contMode_reg, contMode_next, contQuad_reg, contQuad_next;
	logic [7:0] outByte_reg, outByte_next;
	logic [2:0] slot_reg, slot_next;
	logic [3:0] ioOut_reg, ioOut_next, ioOe_reg, ioOe_next;
	logic [ARRAY_ADDR_W-1:0] fetchAddr_reg, fetchAddr_next;
	logic fetchEn_reg, fetchEn_next, pending_reg, pending_next, stale_reg, stale_next;
	logic flush, pop;
	logic [4:0] phaseLen, cntInc;
	logic [23:0] shifted;
	logic [7:0] curByte;
	logic [2:0] lanesNow;

	logic fifoInReady, fifoOutValid;
	logic [DATA_W-1:0] fifoOutData;

	// shift new input bits in at the width of the current phase
	function automatic logic [23:0] shiftIn(input logic [23:0] s, input logic [2:0] lanes, input logic [3:0] io);
		logic [23:0] r;
		r = {s[22:0], io[0]};
		if (lanes == LANES_2) begin
			r = {s[21:0], io[1:0]};
		end else if (lanes == LANES_4) begin
			r = {s[19:0], io[3:0]};
		end
		return r;
	endfunction : shiftIn

	// two flops on every pin before anything looks at it
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			syncA_reg <= 6'h3F;
			syncB_reg <= 6'h3F;
			sclkPrev_reg <= 1'b1;
			csPrev_reg <= 1'b1;
		end else begin
			syncA_reg <= {csN, sclk, ioIn};
			syncB_reg <= syncA_reg;
			sclkPrev_reg <= syncB_reg[4];
			csPrev_reg <= syncB_reg[5];
		end
	end

	// edges seen from the second stage only
	assign csSync = syncB_reg[5];
	assign sclkSync = syncB_reg[4];
	assign ioSync = syncB_reg[3:0];
	assign sclkRise = sclkSync & ~sclkPrev_reg;
	assign sclkFall = ~sclkSync & sclkPrev_reg;
	assign csFall = ~csSync & csPrev_reg;

	// clocks in the current phase
	always_comb begin
		phaseLen = OPCODE_CLKS;
		case (state_reg)
			ST_ADDR: begin
				phaseLen = (addrLanes_reg == LANES_4) ? ADDR_CLKS_X4 :
					(addrLanes_reg == LANES_2) ? ADDR_CLKS_X2 : ADDR_CLKS_X1;
			end
			ST_MODE: begin
				phaseLen = (addrLanes_reg == LANES_4) ? MODE_CLKS_X4 : MODE_CLKS_X2;
			end
			ST_DUMMY: phaseLen = dummyClks_reg;
			default: phaseLen = OPCODE_CLKS;
		endcase
	end

	assign lanesNow = (state_reg == ST_OPCODE) ? LANES_1 : addrLanes_reg;
	assign shifted = shiftIn(shift_reg, lanesNow, ioSync);
	assign cntInc = clkCnt_reg + 5'h01;
	// underrun shows a fixed byte; the array must keep up with the link
	assign curByte = (slot_reg == 3'h0) ? (fifoOutValid ? fifoOutData : UNDERRUN_BYTE) : outByte_reg;

	// command sequencer on link clock edges
	always_comb begin
		state_next = state_reg;
		addrLanes_next = addrLanes_reg;
		dataLanes_next = dataLanes_reg;
		hasMode_next = hasMode_reg;
		dummyClks_next = dummyClks_reg;
		clkCnt_next = clkCnt_reg;
		shift_next = shift_reg;
		contMode_next = contMode_reg;
		contQuad_next = contQuad_reg;
		outByte_next = outByte_reg;
		slot_next = slot_reg;
		ioOut_next = ioOut_reg;
		ioOe_next = ioOe_reg;
		fetchEn_next = fetchEn_reg;
		flush = 1'b0;
		pop = 1'b0;
		if (csSync) begin
			state_next = ST_IDLE;
			ioOe_next = 4'h0;
			ioOut_next = 4'h0;
			fetchEn_next = 1'b0;
			slot_next = 3'h0;
			clkCnt_next = 5'h00;
		end else if (csFall) begin
			clkCnt_next = 5'h00;
			slot_next = 3'h0;
			if (contMode_reg) begin
				addrLanes_next = contQuad_reg ? LANES_4 : LANES_2;
				dataLanes_next = contQuad_reg ? LANES_4 : LANES_2;
				hasMode_next = 1'b1;
				dummyClks_next = contQuad_reg ? DUMMY_CLKS_QUAD_IO : DUMMY_CLKS_NONE;
				state_next = (contQuad_reg && !quadEnable) ? ST_IGNORE : ST_ADDR;
			end else begin
				state_next = ST_OPCODE;
			end
		end else if (sclkRise) begin
			shift_next = shifted;
			clkCnt_next = cntInc;
			case (state_reg)
				ST_OPCODE: begin
					if (cntInc == phaseLen) begin
						clkCnt_next = 5'h00;
						state_next = ST_ADDR;
						hasMode_next = 1'b0;
						case (shifted[7:0])
							CMD_READ_SLOW: begin
								addrLanes_next = LANES_1;
								dataLanes_next = LANES_1;
								dummyClks_next = DUMMY_CLKS_NONE;
							end
							CMD_READ_FAST: begin
								addrLanes_next = LANES_1;
								dataLanes_next = LANES_1;
								dummyClks_next = DUMMY_CLKS_X1;
							end
							CMD_READ_DUAL_OUT: begin
								addrLanes_next = LANES_1;
								dataLanes_next = LANES_2;
								dummyClks_next = DUMMY_CLKS_X1;
							end
							CMD_READ_DUAL_IO: begin
								addrLanes_next = LANES_2;
								dataLanes_next = LANES_2;
								hasMode_next = 1'b1;
								dummyClks_next = DUMMY_CLKS_NONE;
							end
							CMD_READ_QUAD_OUT: begin
								addrLanes_next = LANES_1;
								dataLanes_next = LANES_4;
								dummyClks_next = DUMMY_CLKS_X1;
								state_next = quadEnable ? ST_ADDR : ST_IGNORE;
							end
							CMD_READ_QUAD_IO: begin
								addrLanes_next = LANES_4;
								dataLanes_next = LANES_4;
								hasMode_next = 1'b1;
								dummyClks_next = DUMMY_CLKS_QUAD_IO;
								state_next = quadEnable ? ST_ADDR : ST_IGNORE;
							end
							CMD_MODE_RESET: begin
								contMode_next = CONT_MODE_RESET;
								state_next = ST_IGNORE;
							end
							default: state_next = ST_IGNORE;
						endcase
					end
				end
				ST_ADDR: begin
					if (cntInc == phaseLen) begin
						clkCnt_next = 5'h00;
						// start prefetch at the new address
						flush = 1'b1;
						fetchEn_next = 1'b1;
						state_next = hasMode_reg ? ST_MODE :
							(dummyClks_reg != DUMMY_CLKS_NONE) ? ST_DUMMY : ST_DATA;
					end
				end
				ST_MODE: begin
					if (cntInc == phaseLen) begin
						clkCnt_next = 5'h00;
						contMode_next = (shifted[5:4] == CONT_SELECT);
						contQuad_next = (addrLanes_reg == LANES_4);
						state_next = (dummyClks_reg != DUMMY_CLKS_NONE) ? ST_DUMMY : ST_DATA;
					end
				end
				ST_DUMMY: begin
					if (cntInc == phaseLen) begin
						clkCnt_next = 5'h00;
						state_next = ST_DATA;
					end
				end
				default: clkCnt_next = 5'h00;
			endcase
		end else if (sclkFall && state_reg == ST_DATA) begin
			pop = (slot_reg == 3'h0);
			case (dataLanes_reg)
				LANES_4: begin
					ioOut_next = curByte[7:4];
					ioOe_next = 4'hF;
					outByte_next = {curByte[3:0], 4'h0};
					slot_next = (slot_reg == 3'h1) ? 3'h0 : slot_reg + 3'h1;
				end
				LANES_2: begin
					// bit 7 high line, bit 6 low
					ioOut_next = {2'h0, curByte[7:6]};
					ioOe_next = 4'h3;
					outByte_next = {curByte[5:0], 2'h0};
					slot_next = (slot_reg == 3'h3) ? 3'h0 : slot_reg + 3'h1;
				end
				default: begin
					// msb first on the output line
					ioOut_next = {2'h0, curByte[7], 1'b0};
					ioOe_next = 4'h2;
					outByte_next = {curByte[6:0], 1'b0};
					slot_next = (slot_reg == 3'h7) ? 3'h0 : slot_reg + 3'h1;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			addrLanes_reg <= LANES_1;
			dataLanes_reg <= LANES_1;
			hasMode_reg <= 1'b0;
			dummyClks_reg <= DUMMY_CLKS_NONE;
			clkCnt_reg <= 5'h00;
			shift_reg <= 24'h000000;
			contMode_reg <= CONT_MODE_RESET;
			contQuad_reg <= 1'b0;
			outByte_reg <= 8'h00;
			slot_reg <= 3'h0;
			ioOut_reg <= 4'h0;
			ioOe_reg <= 4'h0;
			fetchEn_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			addrLanes_reg <= addrLanes_next;
			dataLanes_reg <= dataLanes_next;
			hasMode_reg <= hasMode_next;
			dummyClks_reg <= dummyClks_next;
			clkCnt_reg <= clkCnt_next;
			shift_reg <= shift_next;
			contMode_reg <= contMode_next;
			contQuad_reg <= contQuad_next;
			outByte_reg <= outByte_next;
			slot_reg <= slot_next;
			ioOut_reg <= ioOut_next;
			ioOe_reg <= ioOe_next;
			fetchEn_reg <= fetchEn_next;
		end
	end

	assign ioOut = ioOut_reg;
	assign ioOe = ioOe_reg;

	// prefetch: one request in flight, issued only while the fifo has room,
	// so a returning byte always fits and back-pressure reaches the array
	assign memReqValid = fetchEn_reg & ~pending_reg & fifoInReady & ~flush;
	assign memReqAddr = fetchAddr_reg;
	assign memRspReady = stale_reg | fifoInReady;

	always_comb begin
		fetchAddr_next = fetchAddr_reg;
		pending_next = pending_reg;
		stale_next = stale_reg;
		if (memRspValid && memRspReady) begin
			pending_next = 1'b0;
			stale_next = 1'b0;
		end
		if (flush) begin
			fetchAddr_next = shifted[ARRAY_ADDR_W-1:0];
			// a byte still on its way belongs to the old address
			stale_next = pending_reg & ~(memRspValid & memRspReady);
		end else if (memReqValid && memReqReady) begin
			fetchAddr_next = fetchAddr_reg + 1'b1;
			pending_next = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			fetchAddr_reg <= '0;
			pending_reg <= 1'b0;
			stale_reg <= 1'b0;
		end else begin
			fetchAddr_reg <= fetchAddr_next;
			pending_reg <= pending_next;
			stale_reg <= stale_next;
		end
	end

	// prefetched bytes wait here for the link
	byte_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) prefetchFifo (
		.clk(ref_clk),
		.rst(rst),
		.flush(flush),
		.inValid(memRspValid & ~stale_reg),
		.inReady(fifoInReady),
		.inData(memRspData),
		.outValid(fifoOutValid),
		.outReady(pop),
		.outData(fifoOutData)
	);
endmodule : serial_flash_read_path

// ===== hdl/flash_read_pkg.sv
// constants, opcodes and state codes of the serial flash read path
// assumes a single 200 MHz clock domain; pins are synchronised inside the top
package flash_read_pkg;
	// opcodes
	localparam logic [7:0] CMD_READ_SLOW = 8'h03;
	localparam logic [7:0] CMD_READ_FAST = 8'h0B;
	localparam logic [7:0] CMD_READ_DUAL_OUT = 8'h3B;
	localparam logic [7:0] CMD_READ_DUAL_IO = 8'hBB;
	localparam logic [7:0] CMD_READ_QUAD_OUT = 8'h6B;
	localparam logic [7:0] CMD_READ_QUAD_IO = 8'hEB;
	localparam logic [7:0] CMD_MODE_RESET = 8'hFF;
	// array and data widths, fifo depth
	localparam int ARRAY_ADDR_W = 20;
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 8;
	// lane counts, clocks per phase
	localparam logic [2:0] LANES_1 = 3'h1;
	localparam logic [2:0] LANES_2 = 3'h2;
	localparam logic [2:0] LANES_4 = 3'h4;
	localparam logic [4:0] OPCODE_CLKS = 5'h08;
	localparam logic [4:0] ADDR_CLKS_X1 = 5'h18;
	localparam logic [4:0] ADDR_CLKS_X2 = 5'h0C;
	localparam logic [4:0] ADDR_CLKS_X4 = 5'h06;
	localparam logic [4:0] MODE_CLKS_X2 = 5'h04;
	localparam logic [4:0] MODE_CLKS_X4 = 5'h02;
	localparam logic [4:0] DUMMY_CLKS_NONE = 5'h00;
	localparam logic [4:0] DUMMY_CLKS_X1 = 5'h08;
	localparam logic [4:0] DUMMY_CLKS_QUAD_IO = 5'h04;
	// mode byte select value, reset value and underrun byte
	localparam logic [1:0] CONT_SELECT = 2'h2;
	localparam logic CONT_MODE_RESET = 1'b0;
	localparam logic [7:0] UNDERRUN_BYTE = 8'hFF;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_OPCODE = 3'b001,
		ST_ADDR = 3'b010,
		ST_MODE = 3'b011,
		ST_DUMMY = 3'b100,
		ST_DATA = 3'b101,
		ST_IGNORE = 3'b110
	} phase_t;
endpackage : flash_read_pkg

// ===== dv/serial_flash_read_path_checker.sv
// concurrent checks on the pins and array port of the flash read path
// assumes one ref_clk domain with synchronous active-high rst
`timescale 1ns/1ps

module serial_flash_read_path_checker
	import flash_read_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// spi pins
	input wire logic csN,
	input wire logic sclk,
	input wire logic [3:0] ioIn,
	input wire logic [3:0] ioOut,
	input wire logic [3:0] ioOe,
	// status bit
	input wire logic quadEnable,
	// array port
	input wire logic memReqValid,
	input wire logic memReqReady,
	input wire logic [ARRAY_ADDR_W-1:0] memReqAddr,
	input wire logic memRspValid,
	input wire logic memRspReady,
	input wire logic [DATA_W-1:0] memRspData
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic [3:0] fallAge_reg, fallAge_next;
	logic sclkLast_reg, outst_reg, outst_next;
	// age since the last raw sclk fall, saturating so idle time cannot wrap
	always_comb begin
		fallAge_next = fallAge_reg;
		if (sclkLast_reg && !sclk) fallAge_next = 4'h0;
		else if (fallAge_reg != 4'hF) fallAge_next = fallAge_reg + 4'h1;
		outst_next = outst_reg;
		if (memReqValid && memReqReady) outst_next = 1'b1;
		else if (memRspValid && memRspReady) outst_next = 1'b0;
	end
	// helper registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			fallAge_reg <= 4'hF;
			sclkLast_reg <= 1'b0;
			outst_reg <= 1'b0;
		end else begin
			fallAge_reg <= fallAge_next;
			sclkLast_reg <= sclk;
			outst_reg <= outst_next;
		end
	end
	a_reset_quiet_lines: assert property ($fell(rst) |-> ioOe == 4'h0 && !memReqValid)
		else $error("lines or request active after reset");
	a_deselect_release: assert property (csN [*6] |-> ioOe == 4'h0)
		else $error("lines still driven while deselected");
	a_enable_codes: assert property (ioOe == 4'h0 || ioOe == 4'h2 || ioOe == 4'h3 || ioOe == 4'hF)
		else $error("illegal line enable pattern");
	a_quad_needs_enable: assert property (ioOe == 4'hF |-> quadEnable)
		else $error("four lines driven with quad disabled");
	a_req_holds: assert property (memReqValid && !memReqReady && !csN |=> memReqValid && $stable(memReqAddr))
		else $error("request dropped or changed before acceptance");
	a_single_outstanding: assert property (outst_reg |-> !(memReqValid && memReqReady))
		else $error("second request before response");
	a_drive_after_fall: assert property (!csN && $changed({ioOut, ioOe}) |-> fallAge_reg <= 4'h6)
		else $error("data lines changed away from a falling clock");
	a_off_means_zero: assert property ($fell(|ioOe) |-> ioOut == 4'h0)
		else $error("output value left behind at release");
	c_dual: cover property (ioOe == 4'h3);
	c_quad: cover property (ioOe == 4'hF);
	c_top_fetch: cover property (memReqValid && memReqReady && memReqAddr == 20'hFFFFF);
endmodule : serial_flash_read_path_checker

bind serial_flash_read_path serial_flash_read_path_checker chk (.ref_clk(ref_clk), .rst(rst), .csN(csN),
	.sclk(sclk), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .quadEnable(quadEnable), .memReqValid(memReqValid),
	.memReqReady(memReqReady), .memReqAddr(memReqAddr), .memRspValid(memRspValid), .memRspReady(memRspReady),
	.memRspData(memRspData));

// ===== dv/spi_host_model.sv
// spi host stand-in: mode 0, sclk idle low outside frames
// assumes the bench calls its tasks one at a time
`timescale 1ns/1ps

module spi_host_model (
	// pattern clock
	input wire logic ref_clk,
	// pins toward the target
	output logic csN,
	output logic sclk,
	output logic [3:0] ioIn,
	input wire logic [3:0] ioOut,
	input wire logic [3:0] ioOe
);
	logic [3:0] drv = 4'h0;
	logic [3:0] drvOe = 4'h0;
	logic [3:0] junk = 4'h5;
	initial begin
		csN = 1'b1;
		sclk = 1'b0;
	end
	// undriven lines wander so a stale level never passes for data
	always @(posedge ref_clk) junk <= ~junk;
	always_comb begin
		for (int i = 0; i < 4; i++) ioIn[i] = ioOe[i] ? ioOut[i] : (drvOe[i] ? drv[i] : junk[i]);
	end
	task automatic start();
		#40 csN = 1'b0;
		#80;
	endtask : start
	// header bits, released soon after each rising edge
	task automatic send(input logic [7:0] b, input int lanes);
		for (int k = 0; k < 8 / lanes; k++) begin
			drvOe = (lanes == 1) ? 4'h1 : (lanes == 2) ? 4'h3 : 4'hF;
			drv = (lanes == 1) ? {3'h0, b[7]} : (lanes == 2) ? {2'h0, b[7:6]} : b[7:4];
			b = b << lanes;
			#80 sclk = 1'b1;
			#40 drvOe = 4'h0;
			#40 sclk = 1'b0;
		end
	endtask : send
	// sample just before each rising edge
	task automatic recv(output logic [7:0] b, input int lanes);
		logic [3:0] w;
		b = 8'h00;
		for (int k = 0; k < 8 / lanes; k++) begin
			#79 w = ioIn;
			#1 sclk = 1'b1;
			#80 sclk = 1'b0;
			b = (lanes == 1) ? {b[6:0], w[1]} : (lanes == 2) ? {b[5:0], w[1:0]} : {b[3:0], w};
		end
	endtask : recv
	task automatic tick(input int n);
		repeat (n) begin
			#80 sclk = 1'b1;
			#80 sclk = 1'b0;
		end
	endtask : tick
	task automatic stop();
		#40 csN = 1'b1;
		#400;
	endtask : stop
endmodule : spi_host_model

// ===== dv/tb_serial_flash_read_path.sv
// self-checking bench for the flash read path, with an array stand-in
// assumes the host model drives the pins and the package gives opcodes
`timescale 1ns/1ps

module tb_serial_flash_read_path;
	import flash_read_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic quadEnable = 1'b0;
	logic memReqReady = 1'b0;
	logic memRspValid = 1'b0;
	logic [7:0] memRspData = 8'h00;
	wire csN, sclk, memReqValid, memRspReady;
	wire [3:0] ioIn, ioOut, ioOe;
	wire [19:0] memReqAddr;
	int miscompares = 0;
	int samplesChecked = 0;
	logic [31:0] seed = 32'hF844DEDF;
	logic [31:0] arrSeed = 32'hF844DEDF;
	logic reqFire, rspFire;
	logic pend = 1'b0;
	logic hold = 1'b0;
	logic [19:0] reqAddr, pendAddr;
	logic [7:0] got;
	logic [7:0] ops [6] = '{CMD_READ_SLOW, CMD_READ_FAST, CMD_READ_DUAL_OUT, CMD_READ_DUAL_IO,
		CMD_READ_QUAD_OUT, CMD_READ_QUAD_IO};
	always #2.5 ref_clk = ~ref_clk;
	serial_flash_read_path DUT (.ref_clk(ref_clk), .rst(rst), .csN(csN), .sclk(sclk), .ioIn(ioIn),
		.ioOut(ioOut), .ioOe(ioOe), .quadEnable(quadEnable), .memReqValid(memReqValid),
		.memReqReady(memReqReady), .memReqAddr(memReqAddr), .memRspValid(memRspValid),
		.memRspReady(memRspReady), .memRspData(memRspData));
	spi_host_model host (.ref_clk(ref_clk), .csN(csN), .sclk(sclk), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [7:0] arrByte(input logic [19:0] a);
		return a[7:0] ^ a[19:12] ^ 8'h5A;
	endfunction : arrByte
	task automatic chkByte(input string what, input logic [7:0] exp, input logic [7:0] seen);
		samplesChecked++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chkByte
	task automatic chkOe(input string what, input logic [3:0] exp, input logic [3:0] seen);
		samplesChecked++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chkOe
	task automatic close_out();
		if (miscompares == 0 && samplesChecked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : close_out
	// array stand-in: one request in flight, at most one random wait cycle per step
	// longer stalls would starve the first 03h byte, which has only a few cycles of slack
	always @(posedge ref_clk) begin
		reqFire = memReqValid && memReqReady;
		rspFire = memRspValid && memRspReady;
		reqAddr = memReqAddr;
		#1.3;
		arrSeed = lfsr(arrSeed);
		memReqReady = arrSeed[0] | arrSeed[1] | !memReqReady;
		if (rspFire) memRspValid = 1'b0;
		if (reqFire) begin
			pendAddr = reqAddr;
			pend = 1'b1;
			hold = arrSeed[2];
		end else if (pend && !memRspValid && hold) begin
			hold = 1'b0;
		end else if (pend && !memRspValid) begin
			memRspValid = 1'b1;
			memRspData = arrByte(pendAddr);
			pend = 1'b0;
		end
	end
	// one read frame: header per opcode, n bytes checked, then cut clocks and deselect
	task automatic readFrame(input logic [7:0] op, input logic [23:0] addr, input logic [7:0] mode,
		input int n, input int cut, input bit cont);
		int al;
		int dl;
		logic [7:0] b;
		logic [19:0] a;
		al = (op == CMD_READ_DUAL_IO) ? 2 : (op == CMD_READ_QUAD_IO) ? 4 : 1;
		dl = (op == CMD_READ_SLOW || op == CMD_READ_FAST) ? 1 : (op == CMD_READ_QUAD_OUT || al == 4) ? 4 : 2;
		a = addr[19:0];
		host.start();
		if (!cont) host.send(op, 1);
		for (int i = 2; i >= 0; i--) host.send(addr[8*i+:8], al);
		if (al > 1) host.send(mode, al);
		if (al == 4) repeat (2) host.send(8'h00, 4);
		else if (op != CMD_READ_SLOW && al == 1) host.send(8'h00, 1);
		for (int k = 0; k < n; k++) begin
			host.recv(b, dl);
			chkByte("data", arrByte(a), b);
			if (k == 0) chkOe("oe data", dl == 1 ? 4'h2 : dl == 2 ? 4'h3 : 4'hF, ioOe);
			a = a + 20'h1;
		end
		host.tick(cut);
		host.stop();
		chkOe("oe idle", 4'h0, ioOe);
	endtask : readFrame
	initial begin
		repeat (6) @(posedge ref_clk);
		#1.3 rst = 1'b0;
		repeat (4) @(posedge ref_clk);
		#1.3;
		chkOe("oe reset", 4'h0, ioOe);
		seed = lfsr(seed);
		readFrame(CMD_READ_SLOW, seed[23:0], 8'h00, 3, 0, 0);
		readFrame(CMD_READ_FAST, 24'h0FFFFE, 8'h00, 4, 0, 0);
		readFrame(CMD_READ_DUAL_OUT, 24'h0123F0, 8'h00, 2, 0, 0);
		readFrame(CMD_READ_SLOW, 24'h00ABCD, 8'h00, 1, 3, 0);
		host.start();
		host.send(CMD_MODE_RESET, 1);
		host.stop();
		readFrame(CMD_READ_SLOW, 24'h000040, 8'h00, 1, 0, 0);
		readFrame(CMD_READ_DUAL_IO, 24'h0F0F0F, 8'hA5, 2, 0, 0);
		readFrame(CMD_READ_DUAL_IO, 24'h012345, 8'hE3, 2, 0, 1);
		readFrame(CMD_READ_DUAL_IO, 24'h054321, 8'h00, 2, 0, 1);
		readFrame(CMD_READ_SLOW, 24'h000777, 8'h00, 1, 0, 0);
		// both quad opcodes must be refused while the enable bit is clear
		for (int q = 0; q < 2; q++) begin
			host.start();
			host.send(q == 0 ? CMD_READ_QUAD_OUT : CMD_READ_QUAD_IO, 1);
			repeat (4) host.send(8'h00, 1);
			host.tick(4);
			chkOe("oe refused", 4'h0, ioOe);
			host.stop();
		end
		quadEnable = 1'b1;
		readFrame(CMD_READ_QUAD_OUT, 24'h0A0B0C, 8'h00, 2, 0, 0);
		readFrame(CMD_READ_QUAD_IO, 24'h033300, 8'h20, 2, 0, 0);
		readFrame(CMD_READ_QUAD_IO, 24'h044400, 8'h10, 2, 0, 1);
		readFrame(CMD_READ_QUAD_IO, 24'hFFFFFF, 8'h00, 3, 0, 0);
		readFrame(CMD_READ_DUAL_IO, 24'h000100, 8'hA5, 1, 0, 0);
		host.start();
		repeat (4) host.send(8'hFF, 2);
		host.stop();
		readFrame(CMD_READ_SLOW, 24'h000200, 8'h00, 1, 0, 0);
		for (int r = 0; r < 6; r++) begin
			seed = lfsr(seed);
			readFrame(ops[seed[15:8] % 6], seed[23:0], seed[7:0] | 8'h10, 2 + r % 3, 0, 0);
		end
		close_out();
	end
	// hang guard, about twice the expected run length of some 160 us
	initial begin
		#300000;
		miscompares++;
		close_out();
	end
endmodule : tb_serial_flash_read_path
